// ==== include/sef_defs.vh ====
// Register offsets, field positions and reset values for the
// identification status and event flag block.
// Assumes a 32-bit Avalon-MM slave with word addresses (byte addr / 4).
`ifndef SEF_DEFS_VH
`define SEF_DEFS_VH

// Register byte offsets
`define SEF_OFS_ID_BASE 8'h00
`define SEF_OFS_ID_STATUS 8'h04
`define SEF_OFS_EVENT_SET 8'h08
`define SEF_OFS_EVENT_CLEAR 8'h0C
`define SEF_OFS_MASK_SET 8'h10
`define SEF_OFS_MASK_CLEAR 8'h14
`define SEF_OFS_MC_MASK_HI 8'h18
`define SEF_OFS_MC_MASK_LO 8'h1C
`define SEF_OFS_RX_CTRL 8'h20
`define SEF_OFS_RX_SEL 8'h24

// Field positions
`define SEF_ID_ERR_BIT 31
`define SEF_ID_GEN_HI 23
`define SEF_ID_GEN_LO 16
`define SEF_ID_CNT_HI 12
`define SEF_ID_CNT_LO 2
`define SEF_BASE_ALIGN_BITS 11
`define SEF_GIE_BIT 31

`define SEF_EV_SOFT 29
`define SEF_EV_PHY_REG 26
`define SEF_EV_CYC_LONG 25
`define SEF_EV_FATAL 24
`define SEF_EV_CYC_MISM 23
`define SEF_EV_CYC_LOST 22
`define SEF_EV_SIXTY_FOUR 21
`define SEF_EV_CYC_START 20
`define SEF_EV_PHY 19
`define SEF_EV_REG_FAULT 18
`define SEF_EV_BUS_RESET 17
`define SEF_EV_ID_DONE 16
`define SEF_EV_ID_DONE2 15
`define SEF_EV_LOCK_FAULT 9
`define SEF_EV_WRITE_FAULT 8
`define SEF_EV_ISO_RX 7
`define SEF_EV_ISO_TX 6

// Writable event bits and summary bits
`define SEF_EV_WMASK 32'h27FF833F
`define SEF_EV_SUMMARY 32'h000000C0
`define SEF_MASK_WMASK 32'hA7FF83FF

// Reset values
`define SEF_RST_ZERO 32'h00000000
`define SEF_RST_MC 32'h00000000

`endif

// ==== verilog/sef_event_block.v ====
// Identification status, event flags with set/clear aliases, interrupt mask.
// Assumes an Avalon-MM master on ref_clk and event pulses from logic on ref_clk.
//
// Notes on behaviour
// - Store fault while writing identification data sets status bit 31.
// - Eight-bit generation count in bits 23:16 increments per bus reset.
// - Quadlet count in bits 12:2; cleared on every bus reset.
// - Multi-channel mask used only by lowest receive context with option set.
// - Multi-channel context needs fill and header options; single match ignored.
// - Reading the clear alias returns flags AND interrupt mask.
// - Bus reset sets bit 17 and clears bit 16 together.
// - Software may raise any event except bits 7 and 6 by writing one; bit 29 software only.
// - PHY register read done sets bit 26.
// - Cycle overrun as cycle master sets bit 25.
// - Unrecoverable fault sets bit 24.
// - Cycle start mismatch sets bit 23; missing cycle start sets bit 22.
// - Sixty-four second tick sets bit 21; new cycle sets bit 20.
// - PHY interrupt sets bit 19; PHY sources cleared after bit cleared.
// - Register access fault for absent PHY clock sets bit 18.
// - Identification done sets bit 16; repeat while set sets bit 15.
// - Lock response not acknowledged complete sets bit 9.
// - Host bus fault on deferred write sets bit 8.
// - Bits 7 and 6 are read-only ORs of per-channel iso events.
// - Async stored, context done and sent events set bits 5 to 0.
// - Interrupt needs global enable bit 31 and a masked flag set.
//
// The register addresses and register access over Avalon-MM are this design's own decisions.
`include "sef_defs.vh"

module sef_event_block #(
  parameter NUM_RX_CTX = 4,
  parameter NUM_ISO_CH = 4
) (
  input wire ref_clk,
  input wire srst,
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  output reg avs_response_err,
  input wire bus_reset_pulse,
  input wire id_word_stored,
  input wire id_store_fault,
  input wire id_receive_done,
  input wire phy_reg_read_done,
  input wire cycle_master_active,
  input wire cycle_overrun,
  input wire fatal_fault,
  input wire cycle_mismatch,
  input wire cycle_start_missing,
  input wire sixty_four_second_tick,
  input wire cycle_start_seen,
  input wire phy_irq,
  input wire register_access_fault,
  input wire lock_response_fault,
  input wire deferred_write_fault,
  input wire [NUM_ISO_CH-1:0] iso_rx_events,
  input wire [NUM_ISO_CH-1:0] iso_tx_events,
  input wire [5:0] async_events,
  output wire interrupt_out,
  output reg phy_source_clear,
  output reg [NUM_RX_CTX-1:0] multi_channel_grant,
  output reg [NUM_RX_CTX-1:0] single_match_enable,
  output wire [31:0] identification_buffer_base,
  output wire [63:0] multi_channel_receive_mask
);

  // ---------------------------------------------------------------------
  // Bus access decode
  // ---------------------------------------------------------------------
  // One-cycle wait keeps read data registered; answer on second edge.
  reg ack_q;
  wire req = avs_read | avs_write;
  wire take = req & ack_q;
  assign avs_waitrequest = req & ~ack_q;

  wire [7:0] byte_addr = {avs_address, 2'b00};
  // Byte enables widen to a bit mask, one lane at a time.
  wire [31:0] be_mask;
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
      assign be_mask[8*lane+7:8*lane] = {8{avs_byteenable[lane]}};
    end
  endgenerate
  wire [31:0] wdata = avs_writedata & be_mask;

  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // Partial write: lanes not enabled keep their old bits.
  function [31:0] merge_lanes;
    input [31:0] old_v;
    input [31:0] new_v;
    input [31:0] lanes;
    begin
      merge_lanes = (old_v & ~lanes) | (new_v & lanes);
    end
  endfunction

  // ---------------------------------------------------------------------
  // Register write strobes
  // ---------------------------------------------------------------------
  wire wr = take & avs_write;
  wire wr_base = wr & hit(byte_addr, `SEF_OFS_ID_BASE);
  wire wr_ev_set = wr & hit(byte_addr, `SEF_OFS_EVENT_SET);
  wire wr_ev_clr = wr & hit(byte_addr, `SEF_OFS_EVENT_CLEAR);
  wire wr_mk_set = wr & hit(byte_addr, `SEF_OFS_MASK_SET);
  wire wr_mk_clr = wr & hit(byte_addr, `SEF_OFS_MASK_CLEAR);
  wire wr_mc_hi = wr & hit(byte_addr, `SEF_OFS_MC_MASK_HI);
  wire wr_mc_lo = wr & hit(byte_addr, `SEF_OFS_MC_MASK_LO);
  wire wr_rx_ctrl = wr & hit(byte_addr, `SEF_OFS_RX_CTRL);

  // ---------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------
  reg [31:0] base_q;
  reg store_err_q;
  reg [7:0] gen_q;
  reg [10:0] qcount_q;
  reg [31:0] ev_q;
  reg [31:0] mask_q;
  reg [31:0] mc_hi_q;
  reg [31:0] mc_lo_q;
  reg [31:0] rx_ctrl_q;
  reg phy_pending_q;

  // ---------------------------------------------------------------------
  // Status outputs
  // ---------------------------------------------------------------------
  assign identification_buffer_base = base_q;
  assign multi_channel_receive_mask = {mc_hi_q, mc_lo_q};

  // Low address bits are forced to zero so a misaligned base cannot
  // spill packets across the boundary.
  always @(posedge ref_clk) begin
    if (srst) begin
      base_q <= `SEF_RST_ZERO;
    end else if (wr_base) begin
      base_q <= {wdata[31:`SEF_BASE_ALIGN_BITS], {`SEF_BASE_ALIGN_BITS{1'b0}}};
    end
  end

  // ---------------------------------------------------------------------
  // Identification status word
  // ---------------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (srst) begin
      store_err_q <= 1'b0;
      gen_q <= 8'h00;
      qcount_q <= 11'h000;
    end else if (bus_reset_pulse) begin
      gen_q <= gen_q + 8'h01;
      qcount_q <= 11'h000;
      // A fault in the reset cycle still counts: set beats clear here.
      store_err_q <= id_store_fault;
    end else begin
      if (id_store_fault) begin
        store_err_q <= 1'b1;
      end
      if (id_word_stored) begin
        qcount_q <= qcount_q + 11'h001;
      end
    end
  end

  reg [31:0] id_status;
  always @* begin
    id_status = 32'h00000000;
    id_status[`SEF_ID_ERR_BIT] = store_err_q;
    id_status[`SEF_ID_GEN_HI:`SEF_ID_GEN_LO] = gen_q;
    id_status[`SEF_ID_CNT_HI:`SEF_ID_CNT_LO] = qcount_q;
  end

  // ---------------------------------------------------------------------
  // Event flags
  // ---------------------------------------------------------------------
  // Summary bits are not stored; they follow the per-channel registers.
  wire iso_rx_any = |iso_rx_events;
  wire iso_tx_any = |iso_tx_events;

  // ---------------------------------------------------------------------
  // Hardware event sources
  // ---------------------------------------------------------------------
  reg [31:0] hw_set;
  always @* begin
    hw_set = 32'h00000000;
    hw_set[`SEF_EV_PHY_REG] = phy_reg_read_done;
    hw_set[`SEF_EV_CYC_LONG] = cycle_overrun & cycle_master_active;
    hw_set[`SEF_EV_FATAL] = fatal_fault;
    hw_set[`SEF_EV_CYC_MISM] = cycle_mismatch;
    hw_set[`SEF_EV_CYC_LOST] = cycle_start_missing;
    hw_set[`SEF_EV_SIXTY_FOUR] = sixty_four_second_tick;
    hw_set[`SEF_EV_CYC_START] = cycle_start_seen;
    hw_set[`SEF_EV_PHY] = phy_irq;
    hw_set[`SEF_EV_REG_FAULT] = register_access_fault;
    hw_set[`SEF_EV_BUS_RESET] = bus_reset_pulse;
    hw_set[`SEF_EV_ID_DONE] = id_receive_done;
    hw_set[`SEF_EV_ID_DONE2] = id_receive_done & ev_q[`SEF_EV_ID_DONE];
    hw_set[`SEF_EV_LOCK_FAULT] = lock_response_fault;
    hw_set[`SEF_EV_WRITE_FAULT] = deferred_write_fault;
    hw_set[5:0] = async_events;
  end

  // ---------------------------------------------------------------------
  // Flag register
  // ---------------------------------------------------------------------
  wire [31:0] sw_set = wr_ev_set ? (wdata & `SEF_EV_WMASK) : 32'h00000000;
  wire [31:0] sw_clr = wr_ev_clr ? (wdata & `SEF_EV_WMASK) : 32'h00000000;

  // Set terms are ORed after the software clear so it cannot drop an event; the bus reset clear of bits 16 and 15 comes last.
  reg [31:0] ev_d;
  always @* begin
    ev_d = (ev_q & ~sw_clr) | sw_set | hw_set;
    if (bus_reset_pulse) begin
      ev_d[`SEF_EV_ID_DONE] = 1'b0;
      ev_d[`SEF_EV_ID_DONE2] = 1'b0;
    end
    ev_d[`SEF_EV_ISO_RX] = 1'b0;
    ev_d[`SEF_EV_ISO_TX] = 1'b0;
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      ev_q <= `SEF_RST_ZERO;
    end else begin
      ev_q <= ev_d;
    end
  end

  wire [31:0] ev_view = ev_q | {24'h000000, iso_rx_any, iso_tx_any, 6'h00};

  // ---------------------------------------------------------------------
  // PHY source release
  // ---------------------------------------------------------------------
  // PHY sources are released only once the PHY flag has been cleared.
  always @(posedge ref_clk) begin
    if (srst) begin
      phy_pending_q <= 1'b0;
      phy_source_clear <= 1'b0;
    end else begin
      phy_source_clear <= phy_pending_q & ~ev_q[`SEF_EV_PHY];
      if (ev_q[`SEF_EV_PHY]) begin
        phy_pending_q <= 1'b1;
      end else begin
        phy_pending_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Interrupt mask
  // ---------------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (srst) begin
      mask_q <= `SEF_RST_ZERO;
    end else if (wr_mk_set) begin
      mask_q <= mask_q | (wdata & `SEF_MASK_WMASK);
    end else if (wr_mk_clr) begin
      mask_q <= mask_q & ~(wdata & `SEF_MASK_WMASK);
    end
  end

  // Global enable lives in the mask; no flag reaches the pin while it is low.
  wire [31:0] masked_ev = ev_view & mask_q & ~(32'h1 << `SEF_GIE_BIT);
  assign interrupt_out = mask_q[`SEF_GIE_BIT] & (|masked_ev);

  // ---------------------------------------------------------------------
  // Multi-channel receive selection
  // ---------------------------------------------------------------------
  // Four-bit control field per context: bit 0 option, bit 1 fill, bit 2 header keeping.
  always @(posedge ref_clk) begin
    if (srst) begin
      mc_hi_q <= `SEF_RST_MC;
      mc_lo_q <= `SEF_RST_MC;
      rx_ctrl_q <= `SEF_RST_ZERO;
    end else begin
      if (wr_mc_hi) begin
        mc_hi_q <= merge_lanes(mc_hi_q, avs_writedata, be_mask);
      end
      if (wr_mc_lo) begin
        mc_lo_q <= merge_lanes(mc_lo_q, avs_writedata, be_mask);
      end
      if (wr_rx_ctrl) begin
        rx_ctrl_q <= merge_lanes(rx_ctrl_q, avs_writedata, be_mask);
      end
    end
  end

  integer i;
  reg taken;
  reg [NUM_RX_CTX-1:0] grant_d;
  reg [NUM_RX_CTX-1:0] sme_d;
  always @* begin
    taken = 1'b0;
    grant_d = {NUM_RX_CTX{1'b0}};
    sme_d = {NUM_RX_CTX{1'b1}};
    for (i = 0; i < NUM_RX_CTX; i = i + 1) begin
      if (rx_ctrl_q[4*i] && !taken) begin
        taken = 1'b1;
        grant_d[i] = rx_ctrl_q[4*i+1] & rx_ctrl_q[4*i+2];
        sme_d[i] = 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Context selection register
  // ---------------------------------------------------------------------
  // Registered so a context never sees a half-updated selection.
  always @(posedge ref_clk) begin
    if (srst) begin
      multi_channel_grant <= {NUM_RX_CTX{1'b0}};
      single_match_enable <= {NUM_RX_CTX{1'b1}};
    end else begin
      multi_channel_grant <= grant_d;
      single_match_enable <= sme_d;
    end
  end

  // ---------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------
  reg [31:0] rd_d;
  reg rd_err;
  always @* begin
    rd_err = 1'b0;
    case (byte_addr)
      `SEF_OFS_ID_BASE: rd_d = base_q;
      `SEF_OFS_ID_STATUS: rd_d = id_status;
      `SEF_OFS_EVENT_SET: rd_d = ev_view;
      `SEF_OFS_EVENT_CLEAR: rd_d = ev_view & mask_q;
      `SEF_OFS_MASK_SET: rd_d = mask_q;
      `SEF_OFS_MASK_CLEAR: rd_d = mask_q;
      `SEF_OFS_MC_MASK_HI: rd_d = mc_hi_q;
      `SEF_OFS_MC_MASK_LO: rd_d = mc_lo_q;
      `SEF_OFS_RX_CTRL: rd_d = rx_ctrl_q;
      `SEF_OFS_RX_SEL: rd_d = {{(32-NUM_RX_CTX){1'b0}}, multi_channel_grant};
      default: begin
        rd_d = 32'h00000000;
        rd_err = 1'b1;
      end
    endcase
  end

  // ---------------------------------------------------------------------
  // Bus answer
  // ---------------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (srst) begin
      ack_q <= 1'b0;
      avs_readdata <= 32'h00000000;
      avs_response_err <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
      if (req & ~ack_q) begin
        avs_readdata <= avs_read ? rd_d : 32'h00000000;
        avs_response_err <= rd_err;
      end
    end
  end

endmodule // sef_event_block

// ==== tb/sef_event_block_assertions.sv ====
// Port checks for the event flag block.
// Assumes one clock, ref_clk, and srst synchronous active high.
module sef_event_block_checker #(
  parameter NUM_RX_CTX = 4
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic avs_response_err,
  input wire logic interrupt_out,
  input wire logic phy_source_clear,
  input wire logic [NUM_RX_CTX-1:0] multi_channel_grant,
  input wire logic [NUM_RX_CTX-1:0] single_match_enable,
  input wire logic [31:0] identification_buffer_base
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // Clear-alias write of bit 19 taken this edge
  wire clr_take = avs_write && !avs_waitrequest && avs_address == 6'h03 &&
    avs_byteenable[2] && avs_writedata[19];
  sequence s_start; $rose(avs_read || avs_write); endsequence
  sequence s_wait; avs_waitrequest ##1 !avs_waitrequest; endsequence
  property p_wait; s_start |-> s_wait; endproperty
  property p_unmap;
    avs_read && !avs_waitrequest && avs_address > 6'h09 |-> avs_response_err && avs_readdata == '0;
  endproperty
  property p_rst_irq; $fell(srst) |-> !interrupt_out; endproperty
  property p_one; $onehot0(multi_channel_grant); endproperty
  property p_excl; (multi_channel_grant & single_match_enable) == '0; endproperty
  property p_align; identification_buffer_base[10:0] == 11'h000; endproperty
  property p_pulse; phy_source_clear |=> !phy_source_clear; endproperty
  // Pulse must trace back to a software clear of the flag
  property p_cause;
    phy_source_clear |-> $past(clr_take) || $past(clr_take, 2) || $past(clr_take, 3);
  endproperty
  a_wait: assert property (p_wait) else $error("wait state");
  a_unmap: assert property (p_unmap) else $error("unmapped answer");
  a_rst_irq: assert property (p_rst_irq) else $error("irq after reset");
  a_one: assert property (p_one) else $error("grant not unique");
  a_excl: assert property (p_excl) else $error("match not ignored");
  a_align: assert property (p_align) else $error("base alignment");
  a_pulse: assert property (p_pulse) else $error("source clear width");
  a_cause: assert property (p_cause) else $error("source clear cause");
endmodule // sef_event_block_checker

bind sef_event_block sef_event_block_checker #(.NUM_RX_CTX(NUM_RX_CTX)) u_chk (
  .ref_clk(ref_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .avs_response_err(avs_response_err), .interrupt_out(interrupt_out),
  .phy_source_clear(phy_source_clear), .multi_channel_grant(multi_channel_grant),
  .single_match_enable(single_match_enable),
  .identification_buffer_base(identification_buffer_base));

// ==== tb/sef_event_block_bench.sv ====
// Self-checking bench for the event flag block.
// Assumes one wait state per register request, as the block answers.
`include "sef_defs.vh"
module sef_event_block_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [5:0] adr = 6'h00;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wd = 32'h00000000;
  logic [3:0] be = 4'hF;
  logic [31:0] rdata, rd, base;
  logic wait_n, err, irq, psc;
  logic [3:0] grant, sme;
  logic [63:0] mcm;
  logic [20:0] p = '0;
  logic cma = 1'b1;
  logic [3:0] irx = 4'h0;
  logic [3:0] itx = 4'h0;
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n_psc = 0;
  int ebit [18] = '{26, 25, 24, 23, 22, 21, 20, 19, 18, 16, 9, 8, 0, 1, 2, 3, 4, 5};
  sef_event_block DUT (.ref_clk(ref_clk), .srst(srst), .avs_address(adr), .avs_read(rd_en),
    .avs_write(wr_en), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdata),
    .avs_waitrequest(wait_n), .avs_response_err(err), .bus_reset_pulse(p[18]),
    .id_word_stored(p[19]), .id_store_fault(p[20]), .id_receive_done(p[9]),
    .phy_reg_read_done(p[0]), .cycle_master_active(cma), .cycle_overrun(p[1]),
    .fatal_fault(p[2]), .cycle_mismatch(p[3]), .cycle_start_missing(p[4]),
    .sixty_four_second_tick(p[5]), .cycle_start_seen(p[6]), .phy_irq(p[7]),
    .register_access_fault(p[8]), .lock_response_fault(p[10]),
    .deferred_write_fault(p[11]), .iso_rx_events(irx), .iso_tx_events(itx),
    .async_events(p[17:12]), .interrupt_out(irq), .phy_source_clear(psc),
    .multi_channel_grant(grant), .single_match_enable(sme),
    .identification_buffer_base(base), .multi_channel_receive_mask(mcm));
  // ----
  // Clock, watchdog and shared tasks
  // ----
  initial forever #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (psc === 1'b1) n_psc++;
    if (cyc == 5000) begin
      errors++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, seen, exp);
    end
  endtask
  // Hit raises one event pulse so it lands on the edge that takes the request
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input int hit);
    @(posedge ref_clk);
    wr_en <= w;
    rd_en <= !w;
    adr <= a[7:2];
    wd <= d;
    do begin
      @(posedge ref_clk);
      if (wait_n === 1'b1 && hit >= 0) p[hit] <= 1'b1;
    end while (wait_n !== 1'b0);
    rd = rdata;
    p <= '0;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, -1);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000, -1);
    chk(rd, exp);
  endtask
  task automatic pulse(input int k);
    @(posedge ref_clk);
    p[k] <= 1'b1;
    @(posedge ref_clk);
    p[k] <= 1'b0;
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ----
  // Tests
  // ----
  initial begin
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    for (int k = 0; k < 18; k++) begin
      pulse(k);
      rc(`SEF_OFS_EVENT_SET, 32'h00000001 << ebit[k]);
      wr(`SEF_OFS_EVENT_CLEAR, 32'hFFFFFFFF);
    end
    chk(n_psc, 32'h00000001);
    cma <= 1'b0;
    pulse(1);
    rc(`SEF_OFS_EVENT_SET, 32'h00000000);
    $display("done event table");
    repeat (3) pulse(19);
    pulse(20);
    pulse(9);
    pulse(9);
    rc(`SEF_OFS_ID_STATUS, 32'h8000000C);
    rc(`SEF_OFS_EVENT_SET, 32'h00018000);
    pulse(18);
    rc(`SEF_OFS_ID_STATUS, 32'h00010000);
    rc(`SEF_OFS_EVENT_SET, 32'h00020000);
    $display("done bus reset");
    wr(`SEF_OFS_EVENT_SET, 32'hFFFFFFFF);
    rc(`SEF_OFS_EVENT_SET, `SEF_EV_WMASK);
    wr(`SEF_OFS_EVENT_CLEAR, 32'h00000000);
    be <= 4'h1;
    wr(`SEF_OFS_EVENT_CLEAR, 32'hFFFFFFFF);
    be <= 4'hF;
    rc(`SEF_OFS_EVENT_SET, `SEF_EV_WMASK & 32'hFFFFFFC0);
    wr(`SEF_OFS_EVENT_CLEAR, 32'hFFFFFFFF);
    wr(`SEF_OFS_EVENT_SET, 32'h00000003);
    wr(`SEF_OFS_MASK_SET, 32'h00000001);
    rc(`SEF_OFS_EVENT_CLEAR, 32'h00000001);
    @(negedge ref_clk);
    chk({31'h0, irq}, 32'h0);
    wr(`SEF_OFS_MASK_SET, 32'h80000000);
    @(negedge ref_clk);
    chk({31'h0, irq}, 32'h1);
    wr(`SEF_OFS_MASK_CLEAR, 32'h00000001);
    @(negedge ref_clk);
    chk({31'h0, irq}, 32'h0);
    irx <= 4'h4;
    itx <= 4'h1;
    wr(`SEF_OFS_EVENT_CLEAR, 32'hFFFFFFFF);
    rc(`SEF_OFS_EVENT_SET, 32'h000000C0);
    pulse(0);
    bus(1'b1, `SEF_OFS_EVENT_CLEAR, 32'h04000000, 0);
    rc(`SEF_OFS_EVENT_SET, 32'h040000C0);
    $display("done software access");
    wr(`SEF_OFS_RX_CTRL, 32'h00000770);
    rc(`SEF_OFS_RX_SEL, 32'h00000002);
    chk({31'h0, sme[1]}, 32'h0);
    wr(`SEF_OFS_RX_CTRL, 32'h00000771);
    rc(`SEF_OFS_RX_SEL, 32'h00000000);
    wr(`SEF_OFS_ID_BASE, 32'hFFFFF800);
    rc(`SEF_OFS_ID_BASE, 32'hFFFFF800);
    chk(base, 32'hFFFFF800);
    wr(`SEF_OFS_MC_MASK_HI, 32'h89ABCDEF);
    be <= 4'h3;
    wr(`SEF_OFS_MC_MASK_LO, 32'h76543210);
    be <= 4'hF;
    @(negedge ref_clk);
    chk(mcm[63:32], 32'h89ABCDEF);
    chk(mcm[31:0], 32'h00003210);
    wr(8'hFC, 32'hFFFFFFFF);
    rc(8'hFC, 32'h00000000);
    chk({31'h0, err}, 32'h00000001);
    $display("done context and base");
    // Mid-run reset must bring every mapped register back to zero
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    irx <= 4'h0;
    itx <= 4'h0;
    for (int a = 0; a < 10; a++) rc(8'(a * 4), 32'h00000000);
    $display("done reset");
    complete_run();
  end
endmodule // sef_event_block_bench
